// File: common/flash_command_sequencer_consts.vh
// Constants for the flash command sequencer: register offsets, bit
// positions, command codes, reset values and default operation lengths.
// Assumes inclusion by bare name from design and bench files alike.
`ifndef FLASH_COMMAND_SEQUENCER_CONSTS_VH
`define FLASH_COMMAND_SEQUENCER_CONSTS_VH

// ****************************************************************
// Register byte offsets on the APB.
// ****************************************************************
`define FCS_OFS_CONTROL_ZERO  12'h000
`define FCS_OFS_CONTROL_ONE   12'h004
`define FCS_OFS_CONTROL_TWO   12'h008
`define FCS_OFS_STATUS        12'h00C
`define FCS_OFS_WINDOW        12'h400

// ****************************************************************
// Field positions.
// ****************************************************************
`define FCS_BIT_REWRITE_EN    0
`define FCS_BIT_FLASH_STOP    1
`define FCS_BIT_CMD_ABORT     2
`define FCS_BIT_READY_IRQ_EN  3
`define FCS_BIT_LOCK_DISABLE  3
`define FCS_BIT_SUSPEND_EN    0
`define FCS_BIT_SUSPEND_REQ   1
`define FCS_BIT_READY         7
`define FCS_BIT_SUSPENDED     6
`define FCS_BIT_ERASE_ERR     5
`define FCS_BIT_PROG_ERR      4
`define FCS_BIT_LOCK_READOUT  0

// ****************************************************************
// Command codes.
// ****************************************************************
`define FCS_CMD_READ_ARRAY    8'hFF
`define FCS_CMD_CLEAR_STATUS  8'h50
`define FCS_CMD_PROGRAM       8'h40
`define FCS_CMD_BLOCK_ERASE   8'h20
`define FCS_CMD_LOCK_PROGRAM  8'h77
`define FCS_CMD_LOCK_READ     8'h71
`define FCS_CMD_BLANK_CHECK   8'h25
`define FCS_CMD_CONFIRM       8'hD0

// ****************************************************************
// Reset values and operation lengths in pclk cycles.
// ****************************************************************
`define FCS_ERASED_BYTE       8'hFF
`define FCS_LOCK_RESET        1'b1
`define FCS_UNMAPPED_DATA     32'h0000_0000
`define FCS_REFUSED_READ      8'h00
`define FCS_PROG_CYCLES       16
`define FCS_ERASE_CYCLES      64
`define FCS_BLANK_CYCLES      8

`endif

// File: verilog/flash_command_sequencer.v
// Flash rewrite sequencer with a flip-flop array model, reached over APB.
// Assumes one clock pclk, asynchronous active-low presetn, and an APB
// master issuing byte commands through the array window.
//
// The address map and register access over APB were decided locally.
`include "flash_command_sequencer_consts.vh"
`default_nettype none

module flash_command_sequencer #(
  parameter BLK_W        = 2,
  parameter OFS_W        = 4,
  parameter CNT_W        = 16,
  parameter PROG_CYCLES  = `FCS_PROG_CYCLES,
  parameter ERASE_CYCLES = `FCS_ERASE_CYCLES,
  parameter BLANK_CYCLES = `FCS_BLANK_CYCLES
) (
  // APB slave.
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Sequencer state.
  output wire        ready_flag,
  output wire        erase_suspended_flag,
  output reg         ready_irq
);

  localparam ADDR_W = BLK_W + OFS_W;
  localparam NBYTES = 1 << ADDR_W;
  localparam NBLK   = 1 << BLK_W;
  localparam NOFS   = 1 << OFS_W;

  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_PROG  = 2'd1;
  localparam [1:0] ST_ERASE = 2'd2;
  localparam [1:0] ST_BLANK = 2'd3;

  localparam integer PROG_M1  = PROG_CYCLES - 1;
  localparam integer ERASE_M1 = ERASE_CYCLES - 1;
  localparam integer BLANK_M1 = BLANK_CYCLES - 1;
  localparam [CNT_W-1:0] PROG_LAST  = PROG_M1[CNT_W-1:0];
  localparam [CNT_W-1:0] ERASE_LAST = ERASE_M1[CNT_W-1:0];
  localparam [CNT_W-1:0] BLANK_LAST = BLANK_M1[CNT_W-1:0];

  // ****************************************************************
  // Storage and control state.
  // ****************************************************************
  reg [7:0]        mem_q [0:NBYTES-1];
  reg [NBLK-1:0]   lock_q;
  reg [1:0]        state_q;
  reg [CNT_W-1:0]  op_cnt_q;
  reg [CNT_W-1:0]  erase_cnt_q;
  reg [ADDR_W-1:0] op_addr_q;
  reg [7:0]        op_data_q;
  reg              lock_op_q;
  reg [BLK_W-1:0]  erase_blk_q;
  reg              susp_q;
  reg              pend_q;
  reg [7:0]        pend_code_q;
  reg [ADDR_W-1:0] pend_addr_q;
  reg              array_mode_q;
  reg              perr_q;
  reg              eerr_q;
  reg              lock_readout_q;
  reg              ready_q;
  reg              rw_en_q;
  reg              stop_q;
  reg              rie_q;
  reg              lockdis_q;
  reg              susp_en_q;
  reg              susp_req_q;

  // ****************************************************************
  // APB decode.
  // ****************************************************************
  wire             wr_acc   = psel & penable & pwrite;
  wire             aligned  = (paddr[1:0] == 2'b00);
  wire             hit_c0   = aligned & (paddr == `FCS_OFS_CONTROL_ZERO);
  wire             hit_c1   = aligned & (paddr == `FCS_OFS_CONTROL_ONE);
  wire             hit_c2   = aligned & (paddr == `FCS_OFS_CONTROL_TWO);
  wire             hit_st   = aligned & (paddr == `FCS_OFS_STATUS);
  wire [9:0]       win_ofs  = paddr[9:0];
  wire             hit_win  = aligned & (paddr[11:10] == 2'b01) &
                              ((win_ofs[9:2] >> ADDR_W) == 8'h00);
  wire [ADDR_W-1:0] win_idx = win_ofs[ADDR_W+1:2];
  wire [BLK_W-1:0] win_blk  = win_idx[ADDR_W-1:OFS_W];
  wire [7:0]       win_byte = pwdata[7:0];
  wire             mapped   = hit_c0 | hit_c1 | hit_c2 | hit_st | hit_win;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  wire abort_w = wr_acc & hit_c0 & pwdata[`FCS_BIT_CMD_ABORT];
  wire stop_w  = wr_acc & hit_c0 & pwdata[`FCS_BIT_FLASH_STOP];
  wire rwen_w  = ~wr_acc | ~hit_c0 | pwdata[`FCS_BIT_REWRITE_EN];
  // Anything that stops the flash also abandons the running operation.
  wire kill    = abort_w | stop_w | ~rwen_w | ~rw_en_q | stop_q;

  wire ready   = (state_q == ST_IDLE);
  wire cmd_wr  = wr_acc & hit_win & rw_en_q & ~stop_q & ready & ~abort_w;

  // Lock-disable overrides every stored flag without touching it.
  wire win_locked = ~lockdis_q & ~lock_q[win_blk];
  wire on_susp_blk = susp_q & (win_blk == erase_blk_q);

  // ****************************************************************
  // Command decode.
  // ****************************************************************
  reg start_prog;
  reg start_lockp;
  reg start_erase;
  reg start_blank;
  reg seq_err;
  reg set_perr;
  reg set_eerr;
  reg clr_err;
  reg go_array;
  reg take_pend;
  reg read_lock;

  always @* begin
    start_prog  = 1'b0;
    start_lockp = 1'b0;
    start_erase = 1'b0;
    start_blank = 1'b0;
    seq_err     = 1'b0;
    set_perr    = 1'b0;
    set_eerr    = 1'b0;
    clr_err     = 1'b0;
    go_array    = 1'b0;
    take_pend   = 1'b0;
    read_lock   = 1'b0;
    if (cmd_wr && pend_q) begin
      if (pend_code_q == `FCS_CMD_PROGRAM) begin
        if (win_idx != pend_addr_q || on_susp_blk) begin
          seq_err = 1'b1;
        end else if (win_locked) begin
          set_perr = 1'b1;
        end else begin
          start_prog = 1'b1;
        end
      end else if (win_byte == `FCS_CMD_READ_ARRAY) begin
        go_array = 1'b1;
      end else if (win_byte != `FCS_CMD_CONFIRM) begin
        seq_err = 1'b1;
      end else begin
        case (pend_code_q)
          `FCS_CMD_BLOCK_ERASE: begin
            if (susp_q) begin
              seq_err = 1'b1;
            end else if (win_locked) begin
              set_eerr = 1'b1;
            end else begin
              start_erase = 1'b1;
            end
          end
          `FCS_CMD_LOCK_PROGRAM: begin
            if (win_idx != pend_addr_q || win_idx[OFS_W-1:0] != 0 ||
                on_susp_blk) begin
              seq_err = 1'b1;
            end else begin
              start_lockp = 1'b1;
            end
          end
          `FCS_CMD_LOCK_READ: begin
            if (win_idx[OFS_W-1:0] != 0 || on_susp_blk) begin
              seq_err = 1'b1;
            end else begin
              read_lock = 1'b1;
            end
          end
          default: begin
            if (susp_q) begin
              seq_err = 1'b1;
            end else begin
              start_blank = 1'b1;
            end
          end
        endcase
      end
    end else if (cmd_wr) begin
      case (win_byte)
        `FCS_CMD_READ_ARRAY:   go_array = 1'b1;
        `FCS_CMD_CLEAR_STATUS: clr_err  = 1'b1;
        `FCS_CMD_PROGRAM,
        `FCS_CMD_BLOCK_ERASE,
        `FCS_CMD_LOCK_PROGRAM,
        `FCS_CMD_LOCK_READ,
        `FCS_CMD_BLANK_CHECK:  take_pend = 1'b1;
        default:               seq_err  = 1'b1;
      endcase
    end
  end

  // ****************************************************************
  // Operation progress.
  // ****************************************************************
  wire prog_fin  = (state_q == ST_PROG) & (op_cnt_q == PROG_LAST) & ~kill;
  wire blank_fin = (state_q == ST_BLANK) & (op_cnt_q == BLANK_LAST) & ~kill;
  wire erase_fin = (state_q == ST_ERASE) & (erase_cnt_q == ERASE_LAST) &
                   ~kill;
  // Suspension is only looked at while erasing, never while programming.
  wire suspend_now = (state_q == ST_ERASE) & susp_en_q & susp_req_q &
                     ~erase_fin & ~kill;
  wire resume_now  = ready & susp_q & ~susp_req_q & ~kill & ~cmd_wr;
  wire ready_rise  = ready & ~ready_q;

  // Programming can only clear bits, so verify fails on a 0-to-1 attempt.
  wire [7:0] prog_old = mem_q[op_addr_q];
  wire       prog_bad = ((prog_old & op_data_q) != op_data_q);

  reg     blank_ok;
  integer j;
  always @* begin
    blank_ok = 1'b1;
    for (j = 0; j < NOFS; j = j + 1) begin
      if (mem_q[{op_addr_q[ADDR_W-1:OFS_W], j[OFS_W-1:0]}] !=
          `FCS_ERASED_BYTE) begin
        blank_ok = 1'b0;
      end
    end
  end

  // ****************************************************************
  // Sequencer.
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q        <= ST_IDLE;
      op_cnt_q       <= {CNT_W{1'b0}};
      erase_cnt_q    <= {CNT_W{1'b0}};
      op_addr_q      <= {ADDR_W{1'b0}};
      op_data_q      <= 8'h00;
      lock_op_q      <= 1'b0;
      erase_blk_q    <= {BLK_W{1'b0}};
      susp_q         <= 1'b0;
      pend_q         <= 1'b0;
      pend_code_q    <= 8'h00;
      pend_addr_q    <= {ADDR_W{1'b0}};
      array_mode_q   <= 1'b1;
      perr_q         <= 1'b0;
      eerr_q         <= 1'b0;
      lock_readout_q <= 1'b0;
      ready_q        <= 1'b1;
      ready_irq      <= 1'b0;
    end else begin
      ready_q   <= ready;
      ready_irq <= rie_q & (prog_fin | erase_fin |
                            suspend_now);
      if (kill) begin
        state_q <= ST_IDLE;
        susp_q  <= 1'b0;
        pend_q  <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (resume_now) begin
              state_q <= ST_ERASE;
              susp_q  <= 1'b0;
            end
            if (take_pend) begin
              pend_q       <= 1'b1;
              pend_code_q  <= win_byte;
              pend_addr_q  <= win_idx;
              array_mode_q <= 1'b0;
            end else if (cmd_wr) begin
              pend_q <= 1'b0;
            end
            if (start_prog || start_lockp) begin
              state_q   <= ST_PROG;
              op_cnt_q  <= {CNT_W{1'b0}};
              op_addr_q <= win_idx;
              op_data_q <= win_byte;
              lock_op_q <= start_lockp;
            end
            if (start_erase) begin
              state_q     <= ST_ERASE;
              erase_cnt_q <= {CNT_W{1'b0}};
              erase_blk_q <= win_blk;
            end
            if (start_blank) begin
              state_q   <= ST_BLANK;
              op_cnt_q  <= {CNT_W{1'b0}};
              op_addr_q <= win_idx;
            end
            if (go_array) begin
              array_mode_q <= 1'b1;
            end
            if (cmd_wr && !go_array && !take_pend) begin
              array_mode_q <= 1'b0;
            end
            if (read_lock) begin
              lock_readout_q <= lock_q[win_blk];
            end
            if (seq_err) begin
              perr_q <= 1'b1;
              eerr_q <= 1'b1;
            end else if (clr_err) begin
              perr_q <= 1'b0;
              eerr_q <= 1'b0;
            end
            if (set_perr) begin
              perr_q <= 1'b1;
            end
            if (set_eerr) begin
              eerr_q <= 1'b1;
            end
          end
          ST_PROG: begin
            op_cnt_q <= op_cnt_q + 1'b1;
            if (prog_fin) begin
              state_q <= ST_IDLE;
              if (!lock_op_q) begin
                array_mode_q <= 1'b1;
              end
              if (!lock_op_q && prog_bad) begin
                perr_q <= 1'b1;
              end
            end
          end
          ST_ERASE: begin
            erase_cnt_q <= erase_cnt_q + 1'b1;
            if (erase_fin) begin
              state_q      <= ST_IDLE;
              array_mode_q <= 1'b1;
            end else if (suspend_now) begin
              state_q      <= ST_IDLE;
              susp_q       <= 1'b1;
              array_mode_q <= 1'b1;
            end
          end
          default: begin
            op_cnt_q <= op_cnt_q + 1'b1;
            if (blank_fin) begin
              state_q <= ST_IDLE;
              if (!blank_ok) begin
                eerr_q <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Array bytes and lock flags.
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NBYTES; gi = gi + 1) begin : g_byte
      localparam integer      GI  = gi;
      localparam [ADDR_W-1:0] IDX = GI[ADDR_W-1:0];
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem_q[gi] <= `FCS_ERASED_BYTE;
        end else if (prog_fin && !lock_op_q && op_addr_q == IDX) begin
          mem_q[gi] <= mem_q[gi] & op_data_q;
        end else if (erase_fin && IDX[ADDR_W-1:OFS_W] == erase_blk_q) begin
          mem_q[gi] <= `FCS_ERASED_BYTE;
        end
      end
    end
    for (gi = 0; gi < NBLK; gi = gi + 1) begin : g_lock
      localparam integer     GB   = gi;
      localparam [BLK_W-1:0] BIDX = GB[BLK_W-1:0];
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lock_q[gi] <= `FCS_LOCK_RESET;
        end else if (erase_fin && erase_blk_q == BIDX) begin
          lock_q[gi] <= 1'b1;
        end else if (prog_fin && lock_op_q &&
                     op_addr_q[ADDR_W-1:OFS_W] == BIDX) begin
          lock_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Control registers.
  // ****************************************************************
  // Hardware clear beats a software set landing in the same cycle, so
  // a stale enable never survives the event that should end it.
  wire lockdis_clr = erase_fin | ready_rise | seq_err | kill;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rw_en_q    <= 1'b0;
      stop_q     <= 1'b0;
      rie_q      <= 1'b0;
      lockdis_q  <= 1'b0;
      susp_en_q  <= 1'b0;
      susp_req_q <= 1'b0;
    end else begin
      if (wr_acc && hit_c0) begin
        rw_en_q <= pwdata[`FCS_BIT_REWRITE_EN];
        stop_q  <= pwdata[`FCS_BIT_FLASH_STOP];
        rie_q   <= pwdata[`FCS_BIT_READY_IRQ_EN];
      end
      if (lockdis_clr) begin
        lockdis_q <= 1'b0;
      end else if (wr_acc && hit_c1) begin
        lockdis_q <= pwdata[`FCS_BIT_LOCK_DISABLE];
      end
      if (wr_acc && hit_c2) begin
        susp_en_q  <= pwdata[`FCS_BIT_SUSPEND_EN];
        susp_req_q <= pwdata[`FCS_BIT_SUSPEND_REQ];
      end
    end
  end

  // ****************************************************************
  // Read data, captured in the setup cycle.
  // ****************************************************************
  wire [7:0] status_byte = {ready, susp_q, eerr_q, perr_q, 3'b000,
                            lock_readout_q};
  // Reading the suspended block gives a fixed byte, not half-erased data.
  wire [7:0] win_read = (!ready || !array_mode_q) ? status_byte :
                        on_susp_blk ? `FCS_REFUSED_READ :
                        mem_q[win_idx];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `FCS_UNMAPPED_DATA;
    end else if (psel && !penable && !pwrite) begin
      if (hit_c0) begin
        prdata <= {28'h0000000, rie_q, 1'b0, stop_q, rw_en_q};
      end else if (hit_c1) begin
        prdata <= {28'h0000000, lockdis_q, 3'b000};
      end else if (hit_c2) begin
        prdata <= {30'h00000000, susp_req_q, susp_en_q};
      end else if (hit_st) begin
        prdata <= {24'h000000, status_byte};
      end else if (hit_win) begin
        prdata <= {24'h000000, win_read};
      end else begin
        prdata <= `FCS_UNMAPPED_DATA;
      end
    end
  end

  assign ready_flag           = ready;
  assign erase_suspended_flag = susp_q;

endmodule // flash_command_sequencer

`default_nettype wire

// File: bench/flash_command_sequencer_properties.sv
// Checker for the flash command sequencer, watching its top-level ports.
// Assumes one clock pclk and asynchronous active-low presetn.
`include "flash_command_sequencer_consts.vh"
`default_nettype none
module flash_command_sequencer_properties #(
  parameter int ERASE_CYCLES = 64
) (
  // Watched ports.
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        ready_flag,
  input wire logic        erase_suspended_flag,
  input wire logic        ready_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // A resumed erase keeps its progress, so one full erase bounds any wait.
  localparam int BUSY_MAX = ERASE_CYCLES + 4;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_irq_one_pulse: assert property (ready_irq |=> !ready_irq)
    else $error("ready event longer than one cycle");
  a_irq_after_busy: assert property ($rose(ready_irq) |->
    !$past(ready_flag, 1) || !$past(ready_flag, 2))
    else $error("ready event without busy to ready change");
  a_busy_bounded: assert property ($fell(ready_flag) |->
    ##[1:BUSY_MAX] ready_flag) else $error("busy never ends");
  a_busy_on_write: assert property ($fell(ready_flag) |->
    ($past(psel, 1) && $past(penable, 1) && $past(pwrite, 1)) ||
    ($past(psel, 2) && $past(penable, 2) && $past(pwrite, 2)))
    else $error("busy without a write");
  a_suspend_entry: assert property ($rose(erase_suspended_flag) |->
    ready_flag && !$past(ready_flag)) else $error("suspend entry not ready");
  a_resume_busy: assert property ($fell(erase_suspended_flag) &&
    $past(psel, 2) && $past(penable, 2) && $past(pwrite, 2) &&
    $past(paddr, 2) == `FCS_OFS_CONTROL_TWO
    |-> !ready_flag) else $error("resume did not restart erase");
  a_status_mirror: assert property (psel && penable && !pwrite &&
    paddr == `FCS_OFS_STATUS |-> prdata[7] == $past(ready_flag) &&
    prdata[6] == $past(erase_suspended_flag) && prdata[31:8] == 24'h0)
    else $error("status read does not match flags");
  a_busy_window_rd: assert property (psel && penable && !pwrite &&
    paddr[11:8] == 4'h4 && !$past(ready_flag) |-> prdata[7] == 1'b0)
    else $error("window read while busy shows ready");
endmodule // flash_command_sequencer_properties

bind flash_command_sequencer flash_command_sequencer_properties #(
  .ERASE_CYCLES(ERASE_CYCLES)
) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .ready_flag(ready_flag),
  .erase_suspended_flag(erase_suspended_flag), .ready_irq(ready_irq)
);
`default_nettype wire

// File: bench/apb_host.sv
// Host model: issues byte commands, data and register reads over APB.
// Assumes an APB slave on pclk that may insert wait states.
`default_nettype none
module apb_host (
  // Bus.
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output var  logic        psel    = 1'b0,
  output var  logic        penable = 1'b0,
  output var  logic        pwrite  = 1'b0,
  output var  logic [11:0] paddr   = 12'h000,
  output var  logic [31:0] pwdata  = 32'h0000_0000
);
  timeunit 1ns;
  timeprecision 1ps;
  logic timed_out = 1'b0;
  // One transfer; the request stands until pready is sampled high, for at most 64 cycles.
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) timed_out = 1'b1;
    q = (n < 64) ? prdata : 32'hXXXX_XXXX;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released data must not keep looking valid.
    pwdata  <= ~d;
  endtask
endmodule // apb_host
`default_nettype wire

// File: bench/flash_command_sequencer_test.sv
// Testbench for the flash command sequencer: program, errors, locks, suspend.
// Assumes the host model and the bound checker are compiled alongside.
`include "flash_command_sequencer_consts.vh"
`default_nettype none
module flash_command_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PROG = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  wire logic psel, penable, pwrite, pready, pslverr;
  wire logic ready_flag, erase_suspended_flag, ready_irq;
  wire logic [11:0] paddr;
  wire logic [31:0] pwdata, prdata;
  int fail_count = 0, check_count = 0, irq_n = 0;
  logic [31:0] q;
  logic e;
  initial forever #5 pclk = ~pclk;
  always @(posedge pclk) if (ready_irq === 1'b1) irq_n++;
  apb_host m (.pclk(pclk), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  flash_command_sequencer #(.PROG_CYCLES(PROG), .ERASE_CYCLES(16),
    .BLANK_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ready_flag(ready_flag), .erase_suspended_flag(erase_suspended_flag),
    .ready_irq(ready_irq));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, x);
    check_count++;
    if (s !== x) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask
  function automatic logic [11:0] wa(input int i);
    return 12'(`FCS_OFS_WINDOW + 4 * i);
  endfunction
  task automatic bus_ok;
    if (m.timed_out) begin
      fail_count++;
      finish_test();
    end
  endtask
  task automatic w(input logic [11:0] a, input logic [31:0] d);
    m.xfer(1'b1, a, d, q, e);
    bus_ok();
  endtask
  task automatic r(input logic [11:0] a);
    m.xfer(1'b0, a, 32'h0, q, e);
    bus_ok();
  endtask
  task automatic cmd(input int i, input logic [7:0] c1, c2);
    w(wa(i), {24'h0, c1});
    w(wa(i), {24'h0, c2});
  endtask
  // Counts busy cycles at falling edges, where outputs have settled.
  task automatic idle(output int n);
    n = 0;
    @(negedge pclk);
    while (ready_flag !== 1'b1 && n < 300) begin
      n++;
      @(negedge pclk);
    end
    if (n == 300) begin
      fail_count++;
      finish_test();
    end
  endtask
  task automatic st(input logic [31:0] x);
    r(`FCS_OFS_STATUS);
    chk("status", q & ~32'h1, x);
  endtask
  task automatic byte_is(input int i, input logic [31:0] x);
    r(wa(i));
    chk("array byte", q, x);
  endtask
  task automatic lock_rd(input logic x);
    cmd(16, 8'h71, 8'hD0);
    r(`FCS_OFS_STATUS);
    chk("lock flag", {31'h0, q[0]}, {31'h0, x});
  endtask
  task automatic t_program;
    int n, k;
    k = irq_n;
    w(`FCS_OFS_CONTROL_ZERO, 32'h9);
    cmd(1, 8'h40, 8'h5A);
    idle(n);
    chk("busy cycles", n >= PROG - 1 && n <= PROG + 1, 1);
    st(32'h80);
    chk("ready event", irq_n - k, 1);
    byte_is(1, 32'h5A);
    $display("program test done");
  endtask
  task automatic t_errors;
    int n;
    cmd(1, 8'h40, 8'hA5);
    idle(n);
    st(32'h90);
    w(wa(0), 32'h50);
    st(32'h80);
    w(`FCS_OFS_CONTROL_ONE, 32'h8);
    cmd(0, 8'h20, 8'h12);
    st(32'hB0);
    r(`FCS_OFS_CONTROL_ONE);
    chk("lock disable", q, 32'h0);
    w(wa(5), 32'hFF);
    byte_is(0, 32'hFF);
    w(wa(0), 32'h50);
    r(12'h100);
    chk("unmapped", {q[31:1], e}, 32'h1);
    $display("error test done");
  endtask
  task automatic t_lock;
    int n;
    cmd(16, 8'h77, 8'hD0);
    idle(n);
    lock_rd(1'b0);
    cmd(17, 8'h40, 8'h00);
    st(32'h90);
    w(wa(0), 32'h50);
    w(`FCS_OFS_CONTROL_ONE, 32'h8);
    cmd(17, 8'h40, 8'h00);
    idle(n);
    byte_is(17, 32'h00);
    r(`FCS_OFS_CONTROL_ONE);
    chk("lock disable", q, 32'h0);
    lock_rd(1'b0);
    w(`FCS_OFS_CONTROL_ONE, 32'h8);
    cmd(17, 8'h20, 8'hD0);
    r(wa(17));
    chk("busy read", {31'h0, q[7]}, 32'h0);
    idle(n);
    byte_is(17, 32'hFF);
    lock_rd(1'b1);
    cmd(17, 8'h25, 8'hD0);
    idle(n);
    st(32'h80);
    $display("lock test done");
  endtask
  task automatic t_suspend;
    int n, k;
    w(`FCS_OFS_CONTROL_TWO, 32'h1);
    k = irq_n;
    cmd(0, 8'h20, 8'hD0);
    w(`FCS_OFS_CONTROL_TWO, 32'h3);
    idle(n);
    st(32'hC0);
    chk("suspend event", irq_n - k, 1);
    chk("suspend pin", {31'h0, erase_suspended_flag}, 32'h1);
    byte_is(3, 32'h00);
    cmd(32, 8'h40, 8'h3C);
    idle(n);
    chk("busy cycles", n >= PROG - 1 && n <= PROG + 1, 1);
    byte_is(32, 32'h3C);
    cmd(32, 8'h25, 8'hD0);
    st(32'hF0);
    w(wa(0), 32'h50);
    cmd(48, 8'h20, 8'hD0);
    st(32'hF0);
    w(wa(0), 32'h50);
    st(32'hC0);
    k = irq_n;
    w(`FCS_OFS_CONTROL_TWO, 32'h1);
    // Erasure resumes one edge after the write; wait for busy first.
    @(posedge pclk);
    idle(n);
    st(32'h80);
    chk("erase event", irq_n - k, 1);
    byte_is(1, 32'hFF);
    $display("suspend test done");
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_program();
    t_errors();
    t_lock();
    t_suspend();
    finish_test();
  end
endmodule // flash_command_sequencer_test
`default_nettype wire
